// >>> pwe_consts.svh
// Constants for the page-write memory host controller.
`ifndef PWE_CONSTS_SVH
`define PWE_CONSTS_SVH
`define PWE_CLK_MHZ 200
`define PWE_BYTE_WINDOW_US 100
`define PWE_BYTE_WINDOW_CYC ((`PWE_BYTE_WINDOW_US * `PWE_CLK_MHZ) / 2)
`define PWE_WRITE_MS 5
`define PWE_WRITE_CYC (`PWE_WRITE_MS * 1000 * `PWE_CLK_MHZ)
`define PWE_LOCKOUT_US 300
`define PWE_LOCKOUT_CYC (`PWE_LOCKOUT_US * `PWE_CLK_MHZ)
`define PWE_STROBE_CYC 8
`define PWE_POLL_LIMIT 16'hFFFF
`define PWE_PAGE_LSB 7
`define PWE_CMD_A0 18'h0_5555
`define PWE_CMD_A1 18'h0_2AAA
`define PWE_CMD_D0 8'hAA
`define PWE_CMD_D1 8'h55
`define PWE_CMD_DW 8'hA0
`define PWE_CMD_DE 8'h80
`define PWE_CMD_DC 8'h10
`endif

// >>> pwe_pkg.sv
// Types shared by the page-write memory host controller.
package pwe_pkg;
	typedef enum logic [1:0] {
		PWE_OP_READ,
		PWE_OP_WRITE,
		PWE_OP_ERASE
	} pwe_op_t;
	typedef enum {
		PWE_IDLE,
		PWE_CMD,
		PWE_PAGE,
		PWE_GAP,
		PWE_READ,
		PWE_SETTLE,
		PWE_POLL,
		PWE_POLLGAP
	} pwe_state_t;
endpackage

// >>> pwe_stream_if.sv
// Valid-ready byte stream between the controller and its data FIFO.
`timescale 1ns/1ps
interface pwe_stream_if #(
	parameter int WIDTH = 8
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// >>> pwe_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module pwe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	pwe_stream_if.sink inSide,
	pwe_stream_if.source outSide
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inSide.ready = (count_q != (AW+1)'(DEPTH));
	assign outSide.valid = (count_q != '0);
	assign outSide.data = mem[rdPtr_q];
	assign push = inSide.valid && inSide.ready;
	assign pop = outSide.valid && outSide.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inSide.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> pwe_host.sv
// Host controller that reads, page-writes and chip-erases the page-write memory.
`timescale 1ns/1ps
`include "pwe_consts.svh"
module pwe_host
	import pwe_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int PAGE_BYTES = 128,
	parameter int FIFO_DEPTH = 16,
	parameter int STROBE_CYC = `PWE_STROBE_CYC,
	parameter int BYTE_WINDOW_CYC = `PWE_BYTE_WINDOW_CYC,
	parameter int WRITE_CYC = `PWE_WRITE_CYC,
	parameter int LOCKOUT_CYC = `PWE_LOCKOUT_CYC,
	parameter logic [ADDR_W-1:0] CMD_A0 = `PWE_CMD_A0,
	parameter logic [ADDR_W-1:0] CMD_A1 = `PWE_CMD_A1,
	parameter logic [7:0] CMD_D0 = `PWE_CMD_D0,
	parameter logic [7:0] CMD_D1 = `PWE_CMD_D1,
	parameter logic [7:0] CMD_DW = `PWE_CMD_DW,
	parameter logic [7:0] CMD_DE = `PWE_CMD_DE,
	parameter logic [7:0] CMD_DC = `PWE_CMD_DC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [1:0] reqOp,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [7:0] reqCount,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [7:0] wrData,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic opDone,
	output logic opTimeout,
	output logic memAddr,
	output logic [ADDR_W-1:0] memAddrBus,
	output logic chipSel_n,
	output logic outGate_n,
	output logic wrStrobe_n,
	output logic [7:0] dataOut,
	output logic dataOe_n,
	input wire logic [7:0] dataIn
);
	localparam int TW = $clog2(WRITE_CYC + LOCKOUT_CYC + 2);

	pwe_stream_if #(.WIDTH(8)) fillSide ();
	pwe_stream_if #(.WIDTH(8)) drainSide ();

	// Buffering decouples the user stream from strobe timing; drain stalls during strobes.
	pwe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) dataFifo (
		.clk(core_clk),
		.rst(reset),
		.inSide(fillSide),
		.outSide(drainSide)
	);
	assign fillSide.valid = wrValid;
	assign fillSide.data = wrData;
	assign wrReady = fillSide.ready;

	pwe_state_t state_q;
	pwe_op_t op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] left_q;
	logic [2:0] cmdIdx_q;
	logic [2:0] cmdLen_q;
	logic [7:0] lastData_q;
	logic [TW-1:0] timer_q;
	logic [15:0] polls_q;
	logic prevToggle_q;
	logic firstPoll_q;
	logic [7:0] strobeCnt_q;
	logic drainPop;
	logic [ADDR_W-1:0] cmdAddr;
	logic [7:0] cmdData;

	// ----------------------------------------------------------------
	// Command sequence table
	// ----------------------------------------------------------------
	always_comb begin
		cmdAddr = CMD_A0;
		cmdData = CMD_D0;
		unique case (cmdIdx_q)
			3'd1, 3'd4: begin
				cmdAddr = CMD_A1;
				cmdData = CMD_D1;
			end
			3'd2: cmdData = (op_q == PWE_OP_ERASE) ? CMD_DE : CMD_DW;
			3'd5: cmdData = CMD_DC;
			default: begin
				cmdAddr = CMD_A0;
				cmdData = CMD_D0;
			end
		endcase
	end

	assign drainPop = (state_q == PWE_PAGE) && (strobeCnt_q == 8'd0) && drainSide.valid;
	assign drainSide.ready = drainPop;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= PWE_IDLE;
			op_q <= PWE_OP_READ;
			addr_q <= '0;
			left_q <= '0;
			cmdIdx_q <= '0;
			cmdLen_q <= '0;
			lastData_q <= '0;
			timer_q <= '0;
			polls_q <= '0;
			prevToggle_q <= 1'b0;
			firstPoll_q <= 1'b0;
			strobeCnt_q <= '0;
			reqReady <= 1'b0;
			rdValid <= 1'b0;
			rdData <= '0;
			opDone <= 1'b0;
			opTimeout <= 1'b0;
			memAddr <= 1'b0;
			memAddrBus <= '0;
			chipSel_n <= 1'b1;
			outGate_n <= 1'b1;
			wrStrobe_n <= 1'b1;
			dataOut <= '0;
			dataOe_n <= 1'b1;
		end else begin
			rdValid <= 1'b0;
			opDone <= 1'b0;
			opTimeout <= 1'b0;
			reqReady <= (state_q == PWE_IDLE) && !reqReady;
			memAddr <= (state_q != PWE_IDLE);
			unique case (state_q)
				PWE_IDLE: begin
					chipSel_n <= 1'b1;
					outGate_n <= 1'b1;
					wrStrobe_n <= 1'b1;
					dataOe_n <= 1'b1;
					if (reqValid && reqReady) begin
						reqReady <= 1'b0;
						op_q <= pwe_op_t'(reqOp);
						addr_q <= reqAddr;
						// Zero or oversize counts are clamped to one full page.
						left_q <= (reqCount == 8'd0 || reqCount > 8'(PAGE_BYTES)) ?
							8'(PAGE_BYTES) : reqCount;
						cmdIdx_q <= '0;
						cmdLen_q <= (reqOp == 2'(PWE_OP_ERASE)) ? 3'd6 : 3'd3;
						strobeCnt_q <= '0;
						if (reqOp == 2'(PWE_OP_READ)) begin
							state_q <= PWE_READ;
						end else begin
							state_q <= PWE_CMD;
						end
					end
				end
				PWE_CMD: begin
					// Address settles with strobes high, then strobe falls, then data is
					// held until the rising edge; this fixes the capture order.
					strobeCnt_q <= strobeCnt_q + 8'd1;
					if (strobeCnt_q == 8'd0) begin
						memAddrBus <= cmdAddr;
						dataOut <= cmdData;
						dataOe_n <= 1'b0;
						outGate_n <= 1'b1;
						chipSel_n <= 1'b0;
					end else if (strobeCnt_q == 8'd1) begin
						wrStrobe_n <= 1'b0;
					end else if (strobeCnt_q == 8'(STROBE_CYC)) begin
						wrStrobe_n <= 1'b1;
					end else if (strobeCnt_q == 8'(STROBE_CYC + 1)) begin
						strobeCnt_q <= '0;
						cmdIdx_q <= cmdIdx_q + 3'd1;
						if (cmdIdx_q == cmdLen_q - 3'd1) begin
							timer_q <= '0;
							if (op_q == PWE_OP_ERASE) begin
								firstPoll_q <= 1'b1;
								state_q <= PWE_SETTLE;
							end else begin
								state_q <= PWE_PAGE;
							end
						end
					end
				end
				PWE_PAGE: begin
					if (strobeCnt_q == 8'd0) begin
						timer_q <= timer_q + TW'(1);
						if (drainPop) begin
							// Page bits come from the start address; only the column steps.
							memAddrBus <= addr_q;
							dataOut <= drainSide.data;
							lastData_q <= drainSide.data;
							dataOe_n <= 1'b0;
							strobeCnt_q <= 8'd1;
							timer_q <= '0;
						end else if (timer_q >= TW'(BYTE_WINDOW_CYC)) begin
							// Starved source: stop short so the byte window is never missed.
							left_q <= '0;
							state_q <= PWE_GAP;
						end
					end else begin
						strobeCnt_q <= strobeCnt_q + 8'd1;
						if (strobeCnt_q == 8'd1) begin
							wrStrobe_n <= 1'b0;
						end else if (strobeCnt_q == 8'(STROBE_CYC)) begin
							wrStrobe_n <= 1'b1;
						end else if (strobeCnt_q == 8'(STROBE_CYC + 1)) begin
							strobeCnt_q <= '0;
							timer_q <= '0;
							left_q <= left_q - 8'd1;
							if (left_q == 8'd1) begin
								state_q <= PWE_GAP;
							end else begin
								addr_q <= {addr_q[ADDR_W-1:`PWE_PAGE_LSB],
									addr_q[`PWE_PAGE_LSB-1:0] + 7'd1};
							end
						end
					end
				end
				PWE_GAP: begin
					// Strobes idle high; memory's page-load timeout starts its write.
					chipSel_n <= 1'b1;
					dataOe_n <= 1'b1;
					timer_q <= '0;
					firstPoll_q <= 1'b1;
					polls_q <= '0;
					state_q <= PWE_SETTLE;
				end
				PWE_READ: begin
					strobeCnt_q <= strobeCnt_q + 8'd1;
					if (strobeCnt_q == 8'd0) begin
						memAddrBus <= addr_q;
						dataOe_n <= 1'b1;
						chipSel_n <= 1'b0;
						outGate_n <= 1'b0;
					end else if (strobeCnt_q == 8'(STROBE_CYC)) begin
						rdData <= dataIn;
						rdValid <= 1'b1;
						chipSel_n <= 1'b1;
						outGate_n <= 1'b1;
						opDone <= 1'b1;
						state_q <= PWE_IDLE;
					end
				end
				PWE_SETTLE: begin
					state_q <= PWE_POLL;
					strobeCnt_q <= '0;
				end
				PWE_POLL: begin
					strobeCnt_q <= strobeCnt_q + 8'd1;
					timer_q <= timer_q + TW'(1);
					if (strobeCnt_q == 8'd0) begin
						dataOe_n <= 1'b1;
						chipSel_n <= 1'b0;
						outGate_n <= 1'b0;
					end else if (strobeCnt_q == 8'(STROBE_CYC)) begin
						chipSel_n <= 1'b1;
						outGate_n <= 1'b1;
						prevToggle_q <= dataIn[6];
						firstPoll_q <= 1'b0;
						polls_q <= polls_q + 16'd1;
						strobeCnt_q <= '0;
						state_q <= PWE_POLLGAP;
						// Toggle stops and, for writes, bit 7 shows the true value.
						if (!firstPoll_q && (dataIn[6] == prevToggle_q) &&
							(op_q == PWE_OP_ERASE || dataIn[7] == lastData_q[7])) begin
							opDone <= 1'b1;
							state_q <= PWE_IDLE;
						end else if (timer_q >= TW'(WRITE_CYC + LOCKOUT_CYC) ||
							polls_q == `PWE_POLL_LIMIT) begin
							// Covers a lockout after a refused write as well as a hang.
							opTimeout <= 1'b1;
							state_q <= PWE_IDLE;
						end
					end
				end
				PWE_POLLGAP: begin
					timer_q <= timer_q + TW'(1);
					strobeCnt_q <= strobeCnt_q + 8'd1;
					if (strobeCnt_q == 8'(STROBE_CYC)) begin
						strobeCnt_q <= '0;
						state_q <= PWE_POLL;
					end
				end
			endcase
		end
	end
endmodule

// >>> pwe_mem_model.sv
// Behavioural model of the page-write memory as seen at its pins.
`timescale 1ns/1ps
`include "pwe_consts.svh"
module pwe_mem_model #(
	parameter real LOAD_TO = 500.0,
	parameter real WRITE_T = 500.0,
	parameter real LOCK_T = 500.0
) (
	input wire logic [17:0] addr,
	input wire logic chipSel_n,
	input wire logic outGate_n,
	input wire logic wrStrobe_n,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut
);
	logic [7:0] mem [int];
	logic [7:0] pageBuf [128];
	logic loaded [128];
	logic [17:0] cmdA [6];
	logic [7:0] cmdD [6];
	logic [17:0] latA;
	logic [7:0] lastD;
	logic prot = 1'b0, busy = 1'b0, erasing = 1'b0, inLoad = 1'b0, tog = 1'b0, ok;
	int nLoad = 0;
	real lastRise = 0.0;
	initial dataOut = 8'h00;
	// Unloaded flags start clear so the first page write fills its gaps with all ones.
	initial foreach (loaded[i]) loaded[i] = 1'b0;
	function automatic logic isSeq(int b, logic [7:0] d2);
		return cmdA[b] == `PWE_CMD_A0 && cmdD[b] == `PWE_CMD_D0 && cmdA[b+1] == `PWE_CMD_A1
			&& cmdD[b+1] == `PWE_CMD_D1 && cmdA[b+2] == `PWE_CMD_A0 && cmdD[b+2] == d2;
	endfunction
	// ----
	// Load cycles
	// ----
	always @(negedge chipSel_n or negedge wrStrobe_n) begin
		if (!chipSel_n && !wrStrobe_n && outGate_n && !busy) begin
			latA = addr;
			inLoad = 1'b1;
		end
	end
	always @(posedge chipSel_n or posedge wrStrobe_n) begin
		if (inLoad) begin
			inLoad = 1'b0;
			lastD = dataIn;
			lastRise = $realtime;
			if (nLoad < 6) begin
				cmdA[nLoad] = latA;
				cmdD[nLoad] = dataIn;
			end
			if (nLoad >= 3 && isSeq(0, `PWE_CMD_DW)) begin
				pageBuf[latA[6:0]] = dataIn;
				loaded[latA[6:0]] = 1'b1;
			end
			nLoad++;
		end
	end
	// Polling is coarse, but the timeout is far longer than the step.
	always begin
		#5;
		if (nLoad > 0 && !inLoad && $realtime - lastRise > LOAD_TO) begin
			busy = 1'b1;
			erasing = nLoad == 6 && isSeq(0, `PWE_CMD_DE) && isSeq(3, `PWE_CMD_DC);
			ok = erasing || (nLoad > 3 && isSeq(0, `PWE_CMD_DW));
			if (erasing) mem.delete();
			else if (ok) begin
				prot = 1'b1;
				for (int c = 0; c < 128; c++) begin
					mem[{latA[17:7], c[6:0]}] = loaded[c] ? pageBuf[c] : 8'hFF;
					loaded[c] = 1'b0;
				end
			end
			#(ok ? WRITE_T : LOCK_T);
			busy = 1'b0;
			erasing = 1'b0;
			nLoad = 0;
		end
	end
	// ----
	// Read cycles
	// ----
	always @(negedge outGate_n or negedge chipSel_n) begin
		if (!chipSel_n && !outGate_n && wrStrobe_n) begin
			if (busy || nLoad > 0) begin
				tog = ~tog;
				dataOut = {erasing ? tog : ~lastD[7], tog, ~dataOut[5:0]};
			end else dataOut = mem.exists(addr) ? mem[addr] : 8'hFF;
		end
	end
	always @(posedge outGate_n or posedge chipSel_n) dataOut = ~dataOut;
endmodule

// >>> pwe_host_props.sv
// Concurrent checks on the pins and handshakes of the host controller.
`timescale 1ns/1ps
module pwe_host_props #(
	parameter int ADDR_W = 18,
	parameter int STROBE_CYC = 8,
	parameter logic [ADDR_W-1:0] CMD_A0 = '0,
	parameter logic [7:0] CMD_D0 = '0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic [1:0] reqOp,
	input wire logic rdValid,
	input wire logic opDone,
	input wire logic opTimeout,
	input wire logic [ADDR_W-1:0] memAddrBus,
	input wire logic chipSel_n,
	input wire logic outGate_n,
	input wire logic wrStrobe_n,
	input wire logic [7:0] dataOut,
	input wire logic dataOe_n
);
	localparam int RD_LAT = STROBE_CYC + 2;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence sTake(logic [1:0] op);
		reqValid && reqReady && reqOp == op;
	endsequence
	sequence sFirstCmd;
		##[1:20] ($fell(wrStrobe_n) && memAddrBus == CMD_A0 && dataOut == CMD_D0);
	endsequence
	AST_READ_GATE: assert property (!outGate_n |-> dataOe_n && !chipSel_n && wrStrobe_n)
		else $error("Read gate without select or with host driving.");
	AST_WRITE_INHIBIT: assert property (!wrStrobe_n |-> outGate_n && !chipSel_n && !dataOe_n)
		else $error("Write strobe with gate low or select high.");
	AST_STROBE_HOLD: assert property ($fell(wrStrobe_n) |-> !wrStrobe_n [*6])
		else $error("Write strobe pulse too short.");
	AST_LATCH_STABLE: assert property (!wrStrobe_n && !$past(wrStrobe_n)
		|-> $stable(memAddrBus) && $stable(dataOut)) else $error("Address or data moved in load.");
	AST_IDLE_DESELECT: assert property (reqReady |-> chipSel_n && wrStrobe_n && outGate_n)
		else $error("Memory selected while idle.");
	AST_READ_LATENCY: assert property (sTake(2'd0) |-> ##RD_LAT (rdValid && opDone))
		else $error("Read answer late or missing.");
	AST_WRITE_UNLOCK: assert property (sTake(2'd1) |-> sFirstCmd)
		else $error("Page write not opened by unlock sequence.");
	AST_ERASE_START: assert property (sTake(2'd2) |-> sFirstCmd)
		else $error("Erase not opened by command sequence.");
	AST_END_EXCL: assert property (opDone |-> !opTimeout ##1 !opDone)
		else $error("Completion pulse malformed.");
endmodule
bind pwe_host pwe_host_props #(.ADDR_W(ADDR_W), .STROBE_CYC(STROBE_CYC), .CMD_A0(CMD_A0),
	.CMD_D0(CMD_D0)) i_props (.core_clk(core_clk), .reset(reset), .reqValid(reqValid),
	.reqReady(reqReady), .reqOp(reqOp), .rdValid(rdValid), .opDone(opDone),
	.opTimeout(opTimeout), .memAddrBus(memAddrBus), .chipSel_n(chipSel_n),
	.outGate_n(outGate_n), .wrStrobe_n(wrStrobe_n), .dataOut(dataOut), .dataOe_n(dataOe_n));

// >>> page_write_eeprom_access_test.sv
// Self-checking bench for the page-write memory host controller.
`timescale 1ns/1ps
module page_write_eeprom_access_test;
	typedef struct {logic [17:0] a; logic [7:0] n; logic [7:0] s; logic [6:0] p;} pwe_row_t;
	logic core_clk = 0, reset = 1, reqValid = 0, wrValid = 0;
	logic [1:0] reqOp = 0;
	logic [17:0] reqAddr = 0, aBus;
	logic [7:0] reqCount = 0, wrData = 0, memQ, rdData, rdQ, dOut;
	logic reqReady, wrReady, rdValid, opDone, opTimeout, memAddr, csel_n, ogate_n, wstb_n, oe_n;
	int mismatches = 0, checks = 0, cyc = 0;
	pwe_row_t rows [4] = '{'{18'h0_0100, 8'h04, 8'h10, 7'h04}, '{18'h0_0100, 8'h01, 8'hC3, 7'h02},
		'{18'h0_01F8, 8'h10, 8'h80, 7'h08}, '{18'h3_FF80, 8'h02, 8'h7F, 7'h7F}};
	pwe_host #(.BYTE_WINDOW_CYC(50), .WRITE_CYC(400), .LOCKOUT_CYC(100)) i_dut (
		.core_clk(core_clk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
		.reqOp(reqOp), .reqAddr(reqAddr), .reqCount(reqCount), .wrValid(wrValid),
		.wrReady(wrReady), .wrData(wrData), .rdValid(rdValid), .rdData(rdData),
		.opDone(opDone), .opTimeout(opTimeout), .memAddr(memAddr), .memAddrBus(aBus),
		.chipSel_n(csel_n), .outGate_n(ogate_n), .wrStrobe_n(wstb_n), .dataOut(dOut),
		.dataOe_n(oe_n), .dataIn(oe_n ? memQ : dOut));
	// A released bus shows the inverse of the last value, never a kind constant.
	pwe_mem_model i_mem (.addr(aBus), .chipSel_n(csel_n), .outGate_n(ogate_n),
		.wrStrobe_n(wstb_n), .dataIn(oe_n ? ~memQ : dOut), .dataOut(memQ));
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	// ----
	// Shared tasks
	// ----
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(logic [1:0] op, logic [17:0] a, logic [7:0] n);
		int k;
		reqValid <= 1;
		reqOp <= op;
		reqAddr <= a;
		reqCount <= n;
		k = 0;
		do @(posedge core_clk); while (reqReady !== 1'b1 && ++k < 100);
		reqValid <= 0;
		k = 0;
		do @(posedge core_clk); while (opDone !== 1'b1 && opTimeout !== 1'b1 && ++k < 3000);
		rdQ = rdData;
		chk({7'h0, opDone}, 8'h01);
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (5) @(posedge core_clk);
		chk({3'h0, memAddr, csel_n, wstb_n, oe_n, reqReady}, 8'h0E);
		reset <= 0;
		repeat (2) @(posedge core_clk);
		foreach (rows[r]) begin
			wrValid <= 1;
			for (int i = 0; i < rows[r].n; i++) begin
				wrData <= 8'(rows[r].s + i);
				do @(posedge core_clk); while (wrReady !== 1'b1);
			end
			wrValid <= 0;
			@(posedge core_clk);
			if (rows[r].n == 8'h10) chk({7'h0, wrReady}, 8'h00);
			run(2'd1, rows[r].a, rows[r].n);
			for (int i = 0; i < rows[r].n; i++) begin
				run(2'd0, {rows[r].a[17:7], 7'(rows[r].a[6:0] + i)}, 8'h01);
				chk(rdQ, 8'(rows[r].s + i));
			end
			run(2'd0, {rows[r].a[17:7], rows[r].p}, 8'h01);
			chk(rdQ, 8'hFF);
			$display("Row %0d done", r);
		end
		run(2'd2, 18'h0_0000, 8'h01);
		run(2'd0, 18'h0_01F8, 8'h01);
		chk(rdQ, 8'hFF);
		$display("Erase test done");
		reset <= 1;
		repeat (2) @(posedge core_clk);
		chk({3'h0, memAddr, csel_n, wstb_n, oe_n, reqReady}, 8'h0E);
		reset <= 0;
		$display("Reset test done");
		wrap_up();
	end
endmodule
